// file: nest_irq_ctrl.sv
// Nested priority interrupt controller with APB register access and core sequencing.
// How it works
// [RULE1] Four software levels, fourteen vectored sources plus reset and trap.
// [RULE2] Vector addresses sit between FFE0 and FFFF in fixed priority order.
// [RULE3] Service starts at instruction end and pushes PC, X, A, CC.
// [RULE4] After stacking, level bits take the vector's stored priority, then vector loads.
// [RULE5] Return from interrupt restores saved level bits from the stack.
// [RULE6] Level codes: 0=10, 1=01, 2=00, 3=11.
// [RULE7] Highest software priority wins, ties go to higher fixed priority.
// [RULE8] Unserviced requests stay latched until they become the winner.
// [RULE9] Fixed priorities are unique; top-level, reset and trap rank above all levels.
// [RULE10] Non-maskable sources ignore level bits, force level 3, wake halt.
// [RULE11] Trap instruction raises the trap; top-level may preempt its handler.
// [RULE12] Reset is highest and starts code at level 3.
// [RULE13] Maskable source serviced only if enabled and above the current level.
// [RULE14] Top-level request raised by configured edge on its pin.
// [RULE15] Edge external requests latch and clear on entering their handler.
// [RULE16] Selected pins of one group are ORed into one line.
// [RULE17] External lines wake halt; sensitivity chosen by software.
// [RULE18] Peripheral request only while its flag and enable are both set.
// [RULE19] Peripheral clear sequence resets the latch, discarding the pending request.
// [RULE20] Any source wakes wait; only capable ones wake halt.
// [RULE21] After halt the first serviced source must be halt-capable.
// [RULE22] Fixed order rises toward top-level; higher levels preempt in nested use.
// [RULE23] Writing level 0 code to a priority pair keeps the old value.
// [RULE24] Priority registers reset to all ones.
// [RULE25] Enable instruction loads level 0, disable instruction loads level 3.
// [RULE26] Requests are sampled and serviced only at instruction boundaries.
`timescale 1ns/1ps
module nest_irq_ctrl (
    input  wire logic                      pclk,           // Core clock, 20 MHz
    input  wire logic                      presetn,        // Asynchronous reset, active low
    input  wire logic                      psel,           // APB select
    input  wire logic                      penable,        // APB access phase
    input  wire logic                      pwrite,         // APB write
    input  wire logic [7:0]                paddr,          // APB byte address
    input  wire logic [31:0]               pwdata,         // APB write data
    output logic                           pready,         // APB ready
    output logic [31:0]                    prdata,         // APB read data
    output logic                           pslverr,        // APB error on unmapped address
    input  wire nest_irq_pkg::core_ctl_t   core_ctl,       // Core indications
    input  wire nest_irq_pkg::periph_req_t periph,         // Peripheral request sources
    input  wire logic [15:0]               ext_pins,       // External pins, four per line
    input  wire logic                      tli_pin,        // Top-level interrupt pin
    output logic                           hold_core,      // Core stalls while sequencing
    output logic                           stack_push,     // Push one context word
    output logic [1:0]                     stack_sel,      // Word to push: PC, X, A, CC
    output logic                           vector_load,    // Load PC from vector_addr
    output logic [15:0]                    vector_addr,    // Vector address
    output logic                           level_bit_high, // Current level, high bit
    output logic                           level_bit_low,  // Current level, low bit
    output logic                           wake            // Leave wait or halt
);

    nest_irq_pkg::seq_state_t state_q;
    logic [7:0]  vector_sw_priority_regs_q [4];
    logic [8:0]  ext_int_sensitivity_control_q;
    logic [15:0] pin_sel_q;
    logic [1:0]  level_q;
    logic        trap_pend_q;
    logic        halt_exit_q;
    logic [3:0]  target_q;
    logic        target_trap_q;
    logic [1:0]  push_cnt_q;
    logic [13:0] latch_q;
    logic [13:0] pending;
    logic [3:0]  line_prev_q;
    logic        tli_prev_q;
    logic [nest_irq_pkg::NUM_PERIPH-1:0] periph_prev_q;
    logic        first_q;
    logic        found;
    logic [3:0]  win_idx;
    logic [27:0] prio_flat;
    logic        wr_en;
    logic        take;
    logic        entry;
    logic [31:0] rd_d;
    logic        err_d;

    assign prio_flat = {vector_sw_priority_regs_q[3][3:0], vector_sw_priority_regs_q[2],
                        vector_sw_priority_regs_q[1], vector_sw_priority_regs_q[0]};

    // A write lands only at the edge where the access phase sees pready high.
    assign wr_en = psel && penable && pready && pwrite;
    assign take  = (state_q == nest_irq_pkg::ST_IDLE) && core_ctl.instr_boundary // see [RULE26]
                   && (trap_pend_q || found); // see [RULE3]
    assign entry = (state_q == nest_irq_pkg::ST_LOAD);

    nest_irq_arbiter u_arb (
        .pending   (pending),
        .prio_flat (prio_flat),
        .cur_level (level_q),
        .halt_only (halt_exit_q),
        .found     (found),
        .win_idx   (win_idx)
    );

    // Per-source request conditioning.
    genvar s;
    generate
        for (s = 0; s < nest_irq_pkg::NUM_SRC; s++) begin : g_src // see [RULE1]
            if (s == nest_irq_pkg::SRC_TLI) begin : g_tli
                logic edge_hit;
                assign edge_hit = ext_int_sensitivity_control_q[nest_irq_pkg::TLI_EDGE_BIT] ?
                                  (tli_pin && !tli_prev_q) : (!tli_pin && tli_prev_q); // see [RULE14]
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        latch_q[s] <= 1'b0;
                    end else if (edge_hit) begin
                        latch_q[s] <= 1'b1; // see [RULE8]
                    end else if (entry && !target_trap_q && target_q == 4'(s)) begin
                        latch_q[s] <= 1'b0;
                    end
                end
                assign pending[s] = latch_q[s];
            end else if (s >= nest_irq_pkg::SRC_EXT_LO && s <= nest_irq_pkg::SRC_EXT_HI) begin : g_ext
                localparam int L = s - nest_irq_pkg::SRC_EXT_LO;
                logic       line;
                logic [1:0] mode;
                logic       edge_hit;
                assign line = |(ext_pins[L*4+:4] & pin_sel_q[L*4+:4]); // see [RULE16]
                assign mode = ext_int_sensitivity_control_q[L*2+:2]; // see [RULE17]
                assign edge_hit = ((mode == nest_irq_pkg::SENS_RISE || mode == nest_irq_pkg::SENS_BOTH)
                                   && line && !line_prev_q[L])
                               || ((mode == nest_irq_pkg::SENS_FALL || mode == nest_irq_pkg::SENS_BOTH)
                                   && !line && line_prev_q[L]);
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        latch_q[s] <= 1'b0;
                    end else if (edge_hit) begin
                        latch_q[s] <= 1'b1; // see [RULE15]
                    end else if (entry && !target_trap_q && target_q == 4'(s)) begin
                        latch_q[s] <= 1'b0; // see [RULE15]
                    end
                end
                // Low-level mode follows the line itself and is never latched.
                assign pending[s] = (mode == nest_irq_pkg::SENS_LOW) ? !line : latch_q[s];
            end else begin : g_per
                localparam int P = (s == 1) ? 0 : s - nest_irq_pkg::SRC_EXT_HI;
                logic req;
                assign req = periph.flag[P] && periph.enable[P]; // see [RULE18]
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        latch_q[s] <= 1'b0;
                    end else if (req && !periph_prev_q[P]) begin
                        latch_q[s] <= 1'b1; // see [RULE8]
                    end else if (periph.clear[P]) begin
                        latch_q[s] <= 1'b0; // see [RULE19]
                    end
                end
                assign pending[s] = latch_q[s] && req; // see [RULE18]
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_prev_q   <= 4'h0;
            tli_prev_q    <= 1'b0;
            periph_prev_q <= '0;
        end else begin
            for (int l = 0; l < nest_irq_pkg::NUM_EXT; l++) begin
                line_prev_q[l] <= |(ext_pins[l*4+:4] & pin_sel_q[l*4+:4]);
            end
            tli_prev_q    <= tli_pin;
            periph_prev_q <= periph.flag & periph.enable;
        end
    end

    // Software trap latch; the instruction arrives as a one-cycle pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_pend_q <= 1'b0;
        end else if (core_ctl.trap_instr) begin
            trap_pend_q <= 1'b1; // see [RULE11]
        end else if (entry && target_trap_q) begin
            trap_pend_q <= 1'b0;
        end
    end

    // Service sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= nest_irq_pkg::ST_RESET;
            target_q      <= 4'd0;
            target_trap_q <= 1'b0;
            push_cnt_q    <= nest_irq_pkg::PUSH_PC;
        end else begin
            case (state_q)
                nest_irq_pkg::ST_RESET: begin
                    // Reset skips stacking and goes straight to its vector.
                    state_q <= nest_irq_pkg::ST_LOAD; // see [RULE12]
                end
                nest_irq_pkg::ST_IDLE: begin
                    if (take) begin
                        // The trap is taken first; a pending top-level then preempts its handler.
                        target_trap_q <= trap_pend_q; // see [RULE10] [RULE11]
                        target_q      <= win_idx; // see [RULE22]
                        push_cnt_q    <= nest_irq_pkg::PUSH_PC;
                        state_q       <= nest_irq_pkg::ST_STACK;
                    end
                end
                nest_irq_pkg::ST_STACK: begin
                    push_cnt_q <= push_cnt_q + 2'd1; // see [RULE3]
                    if (push_cnt_q == nest_irq_pkg::PUSH_CC) begin
                        state_q <= nest_irq_pkg::ST_LOAD;
                    end
                end
                nest_irq_pkg::ST_LOAD: begin
                    target_trap_q <= 1'b0;
                    state_q       <= nest_irq_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= nest_irq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Core-facing strobes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_push  <= 1'b0;
            stack_sel   <= nest_irq_pkg::PUSH_PC;
            vector_load <= 1'b0;
            vector_addr <= nest_irq_pkg::VEC_RESET;
            hold_core   <= 1'b1;
        end else begin
            stack_push  <= (state_q == nest_irq_pkg::ST_STACK);
            stack_sel   <= push_cnt_q;
            vector_load <= entry; // see [RULE4]
            if (entry) begin
                if (first_q) begin
                    vector_addr <= nest_irq_pkg::VEC_RESET; // see [RULE12]
                end else if (target_trap_q) begin
                    vector_addr <= nest_irq_pkg::VEC_TRAP; // see [RULE2]
                end else begin
                    vector_addr <= nest_irq_pkg::VEC_BASE - {11'd0, target_q, 1'b0}; // see [RULE2]
                end
            end
            hold_core <= (state_q != nest_irq_pkg::ST_IDLE) || take;
        end
    end

    // Marks the single load that follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else if (entry) begin
            first_q <= 1'b0;
        end
    end

    // Current level bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= nest_irq_pkg::LVL3; // see [RULE12]
        end else if (entry) begin
            if (first_q || target_trap_q || target_q == 4'(nest_irq_pkg::SRC_TLI)) begin
                level_q <= nest_irq_pkg::LVL3; // see [RULE10]
            end else begin
                level_q <= prio_flat[2*target_q+:2]; // see [RULE4] [RULE22]
            end
        end else if (core_ctl.cc_load) begin
            level_q <= core_ctl.cc_level; // see [RULE5]
        end else if (core_ctl.interrupt_disable_instr) begin
            level_q <= nest_irq_pkg::LVL3; // see [RULE25]
        end else if (core_ctl.interrupt_enable_instr) begin
            level_q <= nest_irq_pkg::LVL0; // see [RULE25] [RULE6]
        end
    end

    assign level_bit_high = level_q[1];
    assign level_bit_low  = level_q[0];

    // Wake-up and the halt-exit restriction on the first service.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake        <= 1'b0;
            halt_exit_q <= 1'b0;
        end else begin
            wake <= (core_ctl.halt_mode && (|(pending & nest_irq_pkg::HALT_CAPABLE))) // see [RULE17] [RULE20]
                 || (core_ctl.wait_mode && ((|pending) || trap_pend_q)); // see [RULE20]
            if (core_ctl.halt_mode && (|(pending & nest_irq_pkg::HALT_CAPABLE))) begin
                halt_exit_q <= 1'b1; // see [RULE21]
            end else if (entry) begin
                halt_exit_q <= 1'b0;
            end
        end
    end

    // APB slave: one wait state, so pready and prdata both come from flops.
    always_comb begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == nest_irq_pkg::OFF_PRIO0) begin
            rd_d[7:0] = vector_sw_priority_regs_q[0];
        end else if (paddr == nest_irq_pkg::OFF_PRIO1) begin
            rd_d[7:0] = vector_sw_priority_regs_q[1];
        end else if (paddr == nest_irq_pkg::OFF_PRIO2) begin
            rd_d[7:0] = vector_sw_priority_regs_q[2];
        end else if (paddr == nest_irq_pkg::OFF_PRIO3) begin
            rd_d[7:0] = vector_sw_priority_regs_q[3];
        end else if (paddr == nest_irq_pkg::OFF_EXT_SENS) begin
            rd_d[8:0] = ext_int_sensitivity_control_q;
        end else if (paddr == nest_irq_pkg::OFF_PIN_SEL) begin
            rd_d[15:0] = pin_sel_q;
        end else if (paddr == nest_irq_pkg::OFF_STATUS) begin
            rd_d[13:0] = pending;
            rd_d[nest_irq_pkg::STAT_LEVEL_LSB+:2] = level_q;
            rd_d[nest_irq_pkg::STAT_TRAP_BIT]     = trap_pend_q;
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0000_0000;
            pslverr <= psel && penable && !pready && err_d;
        end
    end

    // Priority registers; a pair written with the level 0 code keeps its old value.
    genvar r;
    generate
        for (r = 0; r < 4; r++) begin : g_prio
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    vector_sw_priority_regs_q[r] <= nest_irq_pkg::PRIO_RESET; // see [RULE24]
                end else if (wr_en && paddr == nest_irq_pkg::OFF_PRIO0 + 8'(4 * r)) begin
                    for (int p = 0; p < 4; p++) begin
                        if (pwdata[2*p+:2] != nest_irq_pkg::LVL0 && !(r == 3 && p >= 2)) begin
                            vector_sw_priority_regs_q[r][2*p+:2] <= pwdata[2*p+:2]; // see [RULE23]
                        end
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_int_sensitivity_control_q <= nest_irq_pkg::EXT_SENS_RESET;
            pin_sel_q                     <= nest_irq_pkg::PIN_SEL_RESET;
        end else if (wr_en && paddr == nest_irq_pkg::OFF_EXT_SENS) begin
            ext_int_sensitivity_control_q <= pwdata[8:0]; // see [RULE17]
        end else if (wr_en && paddr == nest_irq_pkg::OFF_PIN_SEL) begin
            pin_sel_q <= pwdata[15:0]; // see [RULE16]
        end
    end

endmodule

// file: nest_irq_pkg.sv
// Shared constants, register map and carrier types of the nested interrupt controller.
package nest_irq_pkg;

    localparam int NUM_SRC     = 14;
    localparam int NUM_EXT     = 4;
    localparam int PINS_PER    = 4;
    localparam int NUM_PERIPH  = 9;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_PRIO0    = 8'h00;
    localparam logic [7:0] OFF_PRIO1    = 8'h04;
    localparam logic [7:0] OFF_PRIO2    = 8'h08;
    localparam logic [7:0] OFF_PRIO3    = 8'h0C;
    localparam logic [7:0] OFF_EXT_SENS = 8'h10;
    localparam logic [7:0] OFF_PIN_SEL  = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;

    // Reset values.
    localparam logic [7:0]  PRIO_RESET     = 8'hFF;
    localparam logic [8:0]  EXT_SENS_RESET = 9'h000;
    localparam logic [15:0] PIN_SEL_RESET  = 16'h0000;

    // Level codes held in the level bits (high, low).
    localparam logic [1:0] LVL0 = 2'b10;
    localparam logic [1:0] LVL1 = 2'b01;
    localparam logic [1:0] LVL2 = 2'b00;
    localparam logic [1:0] LVL3 = 2'b11;

    // External sensitivity codes, two bits per line; bit 8 selects the top-level edge.
    localparam logic [1:0] SENS_LOW     = 2'b00;
    localparam logic [1:0] SENS_RISE    = 2'b01;
    localparam logic [1:0] SENS_FALL    = 2'b10;
    localparam logic [1:0] SENS_BOTH    = 2'b11;
    localparam int         TLI_EDGE_BIT = 8;

    // Status register fields.
    localparam int STAT_LEVEL_LSB = 16;
    localparam int STAT_TRAP_BIT  = 18;

    // Vector addresses; source n uses FFFA minus twice n.
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
    localparam logic [15:0] VEC_BASE  = 16'hFFFA;
    localparam logic [15:0] VEC_LOW   = 16'hFFE0;

    // Source slots: 0 top-level, 2..5 external lines, the rest peripherals.
    localparam int SRC_TLI      = 0;
    localparam int SRC_EXT_LO   = 2;
    localparam int SRC_EXT_HI   = 5;
    localparam logic [13:0] HALT_CAPABLE = 14'h20FF;

    // Context words pushed in order.
    localparam logic [1:0] PUSH_PC = 2'd0;
    localparam logic [1:0] PUSH_CC = 2'd3;

    typedef enum logic [3:0] {
        ST_RESET = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_STACK = 4'b0100,
        ST_LOAD  = 4'b1000
    } seq_state_t;

    // Indications from the processor core, all synchronous to pclk.
    typedef struct packed {
        logic       instr_boundary;
        logic       trap_instr;
        logic       interrupt_enable_instr;
        logic       interrupt_disable_instr;
        logic       cc_load;
        logic [1:0] cc_level;
        logic       halt_mode;
        logic       wait_mode;
    } core_ctl_t;

    // Per-peripheral flag, enable and clear-sequence pulse.
    typedef struct packed {
        logic [NUM_PERIPH-1:0] flag;
        logic [NUM_PERIPH-1:0] enable;
        logic [NUM_PERIPH-1:0] clear;
    } periph_req_t;

endpackage

// file: nest_irq_arbiter.sv
// Combinational winner selection among pending interrupt sources.
`timescale 1ns/1ps
module nest_irq_arbiter (
    input  wire logic [13:0] pending,    // Latched or live requests
    input  wire logic [27:0] prio_flat,  // Stored level code pairs, two bits per source
    input  wire logic [1:0]  cur_level,  // Current level bits
    input  wire logic        halt_only,  // Restrict to halt-capable sources
    output logic             found,      // A source may be serviced
    output logic [3:0]       win_idx     // Winning source slot
);

    function automatic logic [2:0] rank(input logic [1:0] code);
        case (code)
            nest_irq_pkg::LVL0: rank = 3'd0;
            nest_irq_pkg::LVL1: rank = 3'd1;
            nest_irq_pkg::LVL2: rank = 3'd2;
            default:            rank = 3'd3;
        endcase
    endfunction

    logic [13:0]     eligible;
    logic [2:0]      src_rank [14];
    logic [2:0]      best;

    genvar i;
    generate
        for (i = 0; i < 14; i++) begin : g_elig
            // The top-level source outranks every stored level, even level 3.
            assign src_rank[i] = (i == nest_irq_pkg::SRC_TLI) ? 3'd4 : rank(prio_flat[2*i+:2]); // see [RULE9]
            assign eligible[i] = pending[i] && (src_rank[i] > rank(cur_level)) // see [RULE13]
                                 && (!halt_only || nest_irq_pkg::HALT_CAPABLE[i]); // see [RULE21]
        end
    endgenerate

    always_comb begin
        found   = 1'b0;
        win_idx = 4'd0;
        best    = 3'd0;
        // Walking downward with >= lets the lower slot, the higher fixed priority, win ties.
        for (int k = 13; k >= 0; k--) begin
            if (eligible[k] && (!found || src_rank[k] >= best)) begin // see [RULE7]
                found   = 1'b1;
                best    = src_rank[k];
                win_idx = 4'(k);
            end
        end
    end

endmodule

// file: nest_irq_chk.sv
// Concurrent checks on the core side of the interrupt controller.
`timescale 1ns/1ps
module nest_irq_chk (
    input wire logic                    pclk,           // Clock
    input wire logic                    presetn,        // Reset
    input wire nest_irq_pkg::core_ctl_t core_ctl,       // Core
    input wire logic                    hold_core,      // Stall
    input wire logic                    stack_push,     // Push
    input wire logic [1:0]              stack_sel,      // Word
    input wire logic                    vector_load,    // Load
    input wire logic [15:0]             vector_addr,    // Vector
    input wire logic                    level_bit_high, // Level
    input wire logic                    level_bit_low   // Level
);
    logic [1:0] lvl;
    assign lvl = {level_bit_high, level_bit_low};
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_stack;
        stack_push [*4] ##1 vector_load;
    endsequence
    a_stack_walk: assert property ($rose(hold_core) |-> ##1 s_stack)
        else $error("context stacking walk broken");
    a_push_order: assert property (stack_push && $past(stack_push) |-> stack_sel == $past(stack_sel) + 2'h1)
        else $error("push order broken");
    a_take_boundary: assert property ($rose(hold_core) |-> $past(core_ctl.instr_boundary))
        else $error("service started off a boundary");
    a_vec_range: assert property (vector_load |-> vector_addr >= 16'hFFE0 && !vector_addr[0])
        else $error("vector outside table");
    a_nmi_level: assert property (vector_load && vector_addr >= 16'hFFFA |-> lvl == 2'h3)
        else $error("top event not at level 3");
    a_enable_lvl: assert property (core_ctl[6:4] == 3'h4 && !hold_core |=> lvl == 2'h2)
        else $error("enable did not give level 0");
    a_disable_lvl: assert property (core_ctl[5:4] == 2'h2 && !hold_core |=> lvl == 2'h3)
        else $error("disable did not give level 3");
    a_restore_lvl: assert property (core_ctl.cc_load && !hold_core |=> lvl == $past(core_ctl.cc_level))
        else $error("return level not restored");
endmodule
bind nest_irq_ctrl nest_irq_chk i_nest_irq_chk (.pclk, .presetn, .core_ctl, .hold_core, .stack_push, .stack_sel,
    .vector_load, .vector_addr, .level_bit_high, .level_bit_low);

// file: core_model.sv
// Behavioural core that marks instruction ends while not stalled.
`timescale 1ns/1ps
module core_model (
    input  wire logic pclk,      // Clock
    input  wire logic presetn,   // Reset
    input  wire logic hold_core, // Stall
    input  wire logic slow,      // Long instructions
    output logic      boundary   // Instruction end
);
    logic [1:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn) cnt_q <= presetn ? cnt_q + 2'h1 : 2'h0;
    // A stalled core completes nothing, so it never reports an end while held.
    assign boundary = !hold_core && (!slow || cnt_q == 2'h3);
endmodule

// file: test_nest_irq_ctrl.sv
// Self-checking bench for the nested interrupt controller.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h vs %h", $time, a, b); end end
module test_nest_irq_ctrl;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hold_core, stack_push, vector_load, hi, lo;
    logic bnd, slow, top_level_interrupt, wk, w;
    logic [31:0] pwdata, prdata, rd, r;
    logic [15:0] vaddr, pins;
    logic [7:0]  paddr, ctl;
    nest_irq_pkg::periph_req_t pr;
    int n_fail, checked, exp_q[$];
    nest_irq_ctrl i_nest_irq_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .core_ctl({bnd, ctl}), .periph(pr), .ext_pins(pins), .tli_pin(top_level_interrupt), .hold_core, .stack_push,
        .stack_sel(), .vector_load, .vector_addr(vaddr), .level_bit_high(hi), .level_bit_low(lo), .wake(wk));
    core_model i_core_model (.pclk, .presetn, .hold_core, .slow, .boundary(bnd));
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        {err, rd} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
    endtask
    task automatic step(input logic [7:0] c);
        @(posedge pclk) ctl <= c;
        @(posedge pclk) ctl <= 8'h00;
        @(posedge pclk) w = wk;
        repeat (11) @(posedge pclk);
    endtask
    task automatic end_sim;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Every vector entry must match the oldest expectation; an unexpected one never does.
    always @(posedge pclk) begin
        if (presetn && vector_load) `CHK({vaddr, hi, lo}, exp_q.size() ? 18'(exp_q.pop_front()) : 18'h0)
    end
    initial begin
        pclk = 0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        n_fail++;
        end_sim;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ctl, pr, slow, top_level_interrupt} = '0;
        pins = 16'hFFFF;
        void'($urandom(12094));
        exp_q.push_back({16'hFFFE, 2'h3});
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'h00, 0);
        `CHK(rd, 32'h0000_00FF)
        apb(1, 8'h00, 32'h0000_00CF);
        apb(1, 8'h00, 32'h0000_0064);
        apb(0, 8'h00, 0);
        `CHK(rd, 32'h0000_0044)
        apb(0, 8'h1C, 0);
        `CHK({err, rd}, 33'h1_0000_0000)
        r = {16'h0000, 16'($urandom) | 16'h1111};
        apb(1, 8'h14, r);
        apb(0, 8'h14, 0);
        `CHK(rd, r)
        apb(1, 8'h04, 32'h0000_00CF);
        $display("registers done");
        exp_q.push_back({16'hFFEE, 2'h0});
        exp_q.push_back({16'hFFF8, 2'h1});
        pr.enable <= 9'h1FF;
        pr.flag <= 9'h003;
        step(8'h40);
        pr.clear <= 9'h002;
        pr.flag <= 9'h001;
        step(8'h18);
        pr.clear <= 9'h001;
        pr.flag <= 9'h000;
        step(8'h18);
        $display("nesting done");
        pr.clear <= 9'h000;
        step(8'h20);
        `CHK(w, 1'b0)
        pr.flag <= 9'h004;
        step(8'h01);
        `CHK(w, 1'b1)
        pr.clear <= 9'h004;
        step(8'h18);
        $display("discard done");
        pr <= '0;
        slow <= 1'b1;
        exp_q.push_back({16'hFFFC, 2'h3});
        exp_q.push_back({16'hFFFA, 2'h3});
        top_level_interrupt <= 1'b1;
        step(8'h80);
        top_level_interrupt <= 1'b0;
        step(8'h00);
        step(8'h18);
        `CHK(exp_q.size(), 0)
        $display("trap done");
        end_sim;
    end
endmodule
